// File: rtl/rsx_consts.svh
// constants for the rotate/subtract/swap/xor datapath
`ifndef RSX_CONSTS_SVH
`define RSX_CONSTS_SVH
`define RSX_DATA_W 8
`define RSX_ADDR_W 5
`define RSX_FILE_DEPTH 32
`define RSX_DIR_SEL 3'h6
`define RSX_ACC_RST 8'h00
`define RSX_FILE_RST 8'h00
`define RSX_DIR_RST 8'hff
`define RSX_FLAGS_RST 3'h0
`define RSX_DEST_ACC 1'b0
`define RSX_DEST_FILE 1'b1
`endif

// File: rtl/rsx_pkg.sv
// types for the rotate/subtract/swap/xor datapath
package rsx_pkg;
   typedef enum logic [2:0] {
      RSX_OP_NONE = 3'b000,
      RSX_OP_ROTL = 3'b001,
      RSX_OP_ROTR = 3'b010,
      RSX_OP_SUB = 3'b011,
      RSX_OP_SWAP = 3'b100,
      RSX_OP_DIR = 3'b101,
      RSX_OP_XORL = 3'b110,
      RSX_OP_XORF = 3'b111
   } rsx_op_e;

   typedef struct packed {
      rsx_op_e op;
      logic dest;
      logic [4:0] faddr;
      logic [7:0] literal;
      logic [2:0] dir_sel;
   } rsx_instr_s;

   typedef struct packed {
      logic carry;
      logic digit_carry;
      logic zero;
   } rsx_flags_s;
endpackage

// File: rtl/rsx_alu.sv
// combinational result and flag computation
`timescale 1ns/1ps
`include "rsx_consts.svh"
module rsx_alu
   import rsx_pkg::*;
(
   // operation and operands
   input wire rsx_op_e i_op,
   input wire logic [7:0] i_acc,
   input wire logic [7:0] i_src,
   input wire logic [7:0] i_literal,
   input wire rsx_flags_s i_flags,
   // result
   output logic [7:0] o_result,
   output rsx_flags_s o_flags
);
   logic [8:0] diff;
   logic [4:0] ndiff;

   // compute result; flags not named for an op keep their value
   always_comb begin
      diff = {1'b0, i_src} + {1'b0, ~i_acc} + 9'h001;
      ndiff = {1'b0, i_src[3:0]} + {1'b0, ~i_acc[3:0]} + 5'h01;
      o_result = i_src;
      o_flags = i_flags;
      unique case (i_op)
         RSX_OP_ROTL: begin
            o_result = {i_src[6:0], i_flags.carry};
            o_flags.carry = i_src[7];
         end
         RSX_OP_ROTR: begin
            o_result = {i_flags.carry, i_src[7:1]};
            o_flags.carry = i_src[0];
         end
         RSX_OP_SUB: begin
            // file minus acc, carry set means no borrow
            o_result = diff[7:0];
            o_flags.carry = diff[8];
            o_flags.digit_carry = ndiff[4];
            o_flags.zero = (diff[7:0] == 8'h00);
         end
         RSX_OP_SWAP: begin
            o_result = {i_src[3:0], i_src[7:4]};
         end
         RSX_OP_XORL: begin
            o_result = i_acc ^ i_literal;
            o_flags.zero = ((i_acc ^ i_literal) == 8'h00);
         end
         RSX_OP_XORF: begin
            o_result = i_acc ^ i_src;
            o_flags.zero = ((i_acc ^ i_src) == 8'h00);
         end
         RSX_OP_DIR: begin
            // direction load passes acc, no flags
            o_result = i_acc;
         end
         RSX_OP_NONE: begin
            o_result = i_src;
         end
      endcase
   end
endmodule

// File: rtl/rsx_core.sv
// datapath with accumulator, file space, direction register and flags
// instruction fields, sampled on a rising edge with i_valid high
//    op: which operation, from the package enum
//    dest: 0 steers to the accumulator, 1 back to the file entry
//    faddr: file entry 0..31, also the operand source
//    literal: eight-bit constant, read only by the literal xor
//    dir_sel: direction register selector, only 6 exists here
//
// result and flags per operation
//    rotate left: {src[6:0], carry}, carry takes src[7]
//    rotate right: {carry, src[7:1]}, carry takes src[0]
//    rotates leave digit carry and zero alone
//    subtract: src plus inverted acc plus one, nine bits wide
//    subtract carry: set when no borrow, src not below acc
//    subtract digit carry: set when the low nibble needs no borrow
//    subtract zero: set when the eight-bit difference is zero
//    nibble exchange: {src[3:0], src[7:4]}, flags untouched
//    direction load: acc copied to the direction register
//    direction load: flags untouched, acc unchanged
//    literal xor: acc ^ literal into acc, dest ignored
//    literal xor: only the zero flag moves
//    file xor: acc ^ src, steered by dest
//    file xor: only the zero flag moves
//    no-op code: nothing written, flags untouched
//
// timing
//    one instruction per edge, back to back allowed
//    results visible right after the taking edge, which registers them
//    each instruction sees the results of the one before it
//    operand read is combinational from the file array
//    read port shows the entry after that edge's write
//    no stall: the decoder owns the spacing of instructions
//
// reset
//    asynchronous, active low on i_reset_n
//    accumulator and flags clear
//    direction register reads all ones, every pin an input
//    file entries clear, so first reads are defined
//    first instruction may arrive one edge after release
//
// limitations
//    no special registers alias the file space here
//    flags live apart, so writing an entry never changes them
//    a selector other than 6 is quietly ignored
//    i_instr fields are don't-care while i_valid is low
//
// trade-offs
//    file space is flops, not a memory macro, so reset can clear it
//    the alu is purely combinational, one level of logic per cycle
//    flags update only through the alu, so untouched bits stay put
//    the read port is registered to keep o_file_rdata a flop output
`timescale 1ns/1ps
`include "rsx_consts.svh"
module rsx_core
   import rsx_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // instruction from decoder, one per cycle when valid
   input wire logic i_valid,
   input wire rsx_instr_s i_instr,
   // state seen by the rest of the core
   output logic [7:0] o_acc,
   output rsx_flags_s o_flags,
   output logic [7:0] o_pin_direction,
   output logic [7:0] o_file_rdata,
   input wire logic [4:0] i_file_raddr
);
   // storage for the file entries and their next values
   logic [7:0] file_q [`RSX_FILE_DEPTH];
   logic [7:0] file_d [`RSX_FILE_DEPTH];

   // architectural state and next values
   logic [7:0] acc_q, acc_d;
   logic [7:0] dir_q, dir_d;
   logic [7:0] rdata_q, rdata_d;
   rsx_flags_s flags_q, flags_d;

   // alu operand and outputs
   logic [7:0] src;
   logic [7:0] result;
   rsx_flags_s alu_flags;

   // returns true when an op writes its result via the dest selector
   function automatic logic routed(input rsx_op_e op);
      routed = (op == RSX_OP_ROTL) || (op == RSX_OP_ROTR) || (op == RSX_OP_SUB)
         || (op == RSX_OP_SWAP) || (op == RSX_OP_XORF);
   endfunction

   // true when the result lands in the accumulator
   function automatic logic writes_acc(input rsx_op_e op, input logic dest);
      writes_acc = (routed(op) && dest == `RSX_DEST_ACC) || (op == RSX_OP_XORL);
   endfunction

   // true when the result lands back in the addressed file entry
   function automatic logic writes_file(input rsx_op_e op, input logic dest);
      writes_file = routed(op) && dest == `RSX_DEST_FILE;
   endfunction

   // true when the one implemented direction register is loaded
   function automatic logic loads_dir(input rsx_op_e op, input logic [2:0] sel);
      loads_dir = (op == RSX_OP_DIR) && (sel == `RSX_DIR_SEL);
   endfunction

   // operand fetch from the addressed file entry
   assign src = file_q[i_instr.faddr];

   rsx_alu u_alu (
      .i_op(i_instr.op),
      .i_acc(acc_q),
      .i_src(src),
      .i_literal(i_instr.literal),
      .i_flags(flags_q),
      .o_result(result),
      .o_flags(alu_flags)
   );

   // dest 0 or literal xor to acc
   always_comb begin
      acc_d = acc_q;
      if (i_valid && writes_acc(i_instr.op, i_instr.dest)) begin
         acc_d = result;
      end
   end

   // accumulator register
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         acc_q <= `RSX_ACC_RST;
      end else begin
         acc_q <= acc_d;
      end
   end

   // flags next value; the alu already holds untouched bits steady
   always_comb begin
      flags_d = flags_q;
      if (i_valid) begin
         flags_d = alu_flags;
      end
   end

   // status flag register
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         flags_q <= `RSX_FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   // only selector 6 loads; others ignored
   always_comb begin
      dir_d = dir_q;
      if (i_valid && loads_dir(i_instr.op, i_instr.dir_sel)) begin
         dir_d = acc_q;
      end
   end

   // direction register, all inputs after reset
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dir_q <= `RSX_DIR_RST;
      end else begin
         dir_q <= dir_d;
      end
   end

   // next-state for the file space, one entry per generate slice
   for (genvar g = 0; g < `RSX_FILE_DEPTH; g++) begin : g_file
      always_comb begin
         file_d[g] = file_q[g];
         // dest 1 writes back the file entry
         if (i_valid && writes_file(i_instr.op, i_instr.dest) && i_instr.faddr == 5'(g)) begin
            file_d[g] = result;
         end
      end
      always_ff @(posedge i_mclk or negedge i_reset_n) begin
         if (!i_reset_n) begin
            file_q[g] <= `RSX_FILE_RST;
         end else begin
            file_q[g] <= file_d[g];
         end
      end
   end

   // registered read port, shows post-write contents right after the writing edge
   always_comb begin
      rdata_d = file_d[i_file_raddr];
   end

   // read-back register
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdata_q <= `RSX_FILE_RST;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign o_acc = acc_q;
   assign o_flags = flags_q;
   assign o_pin_direction = dir_q;
   assign o_file_rdata = rdata_q;
endmodule

// File: dv/rsx_core_checker.sv
// assertions on the ports of the datapath core
`timescale 1ns/1ps
module rsx_core_checker
   import rsx_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // instruction and visible state
   input wire logic i_valid,
   input wire rsx_instr_s i_instr,
   input wire logic [7:0] o_acc,
   input wire rsx_flags_s o_flags,
   input wire logic [7:0] o_pin_direction,
   input wire logic [7:0] o_file_rdata,
   input wire logic [4:0] i_file_raddr
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   // idle reads as the no-op code, so op alone implies valid
   wire [2:0] op = i_valid ? i_instr.op : 3'h0;
   wire d = i_instr.dest;
   a_xorl_acc: assert property (op == RSX_OP_XORL |=> o_acc == ($past(o_acc) ^
      $past(i_instr.literal)) && o_flags.zero == (o_acc == 8'h00)) else $error("xorl");
   a_rot_flags: assert property (op == RSX_OP_ROTL || op == RSX_OP_ROTR |=>
      $stable(o_flags.zero) && $stable(o_flags.digit_carry)) else $error("rot flags");
   a_rotl_carry: assert property (op == RSX_OP_ROTL && !d |=>
      o_acc[0] == $past(o_flags.carry)) else $error("rotl carry in");
   a_rotr_carry: assert property (op == RSX_OP_ROTR && !d |=>
      o_acc[7] == $past(o_flags.carry)) else $error("rotr carry in");
   a_swap_flags: assert property (op == RSX_OP_SWAP |=> $stable(o_flags))
      else $error("swap flags");
   a_dir_load: assert property (op == RSX_OP_DIR && i_instr.dir_sel == 3'h6 |=>
      o_pin_direction == $past(o_acc) && $stable(o_flags)) else $error("dir load");
   a_sub_zero: assert property (op == RSX_OP_SUB && !d |=>
      o_flags.zero == (o_acc == 8'h00)) else $error("sub zero");
   a_xorf_zero: assert property (op == RSX_OP_XORF && !d |=>
      o_flags.zero == (o_acc == 8'h00) && $stable(o_flags.carry)) else $error("xorf");
   a_dest_file_acc: assert property ((op == RSX_OP_ROTL || op == RSX_OP_ROTR
      || op == RSX_OP_SUB || op == RSX_OP_SWAP || op == RSX_OP_XORF) && d |=> $stable(o_acc))
      else $error("dest file touched acc");
   a_dir_ignore: assert property (op == RSX_OP_DIR && i_instr.dir_sel != 3'h6 |=>
      $stable(o_pin_direction)) else $error("dir selector ignored");
endmodule
bind rsx_core rsx_core_checker u_chk (.i_mclk, .i_reset_n, .i_valid, .i_instr, .o_acc,
   .o_flags, .o_pin_direction, .o_file_rdata, .i_file_raddr);

// File: dv/rsx_core_test.sv
// self-checking bench for the datapath core
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
   $display("[FAIL] %0t mismatch", $time); end end
module rsx_core_test;
   import rsx_pkg::*;
   // stimulus and observed state
   logic i_mclk = 1'b0, i_reset_n = 1'b0, i_valid = 1'b0;
   rsx_instr_s i_instr = '0;
   logic [4:0] i_file_raddr = 5'h00;
   logic [7:0] o_acc, o_pin_direction, o_file_rdata;
   rsx_flags_s o_flags;
   int miscompares = 0, comparisons = 0;
   // 125 MHz clock
   always #4 i_mclk = ~i_mclk;
   rsx_core dut (.i_mclk, .i_reset_n, .i_valid, .i_instr, .o_acc, .o_flags,
      .o_pin_direction, .o_file_rdata, .i_file_raddr);
   // one instruction, then check acc, flags {c,dc,z} and read-back of the same entry
   task automatic step(rsx_op_e op, logic d, logic [4:0] f, logic [7:0] k, logic [2:0] s,
      logic [7:0] ea, logic [2:0] ef, logic [7:0] er);
      @(posedge i_mclk);
      i_valid <= 1'b1;
      i_instr <= '{op, d, f, k, s};
      i_file_raddr <= f;
      @(posedge i_mclk);
      i_valid <= 1'b0;
      #1;
      `CHK(o_acc, ea)
      `CHK(o_flags, ef)
      `CHK(o_file_rdata, er)
   endtask
   task automatic t_logic();
      step(RSX_OP_XORL, 1'b1, 5'h00, 8'ha5, 3'h0, 8'ha5, 3'h0, 8'h00);
      step(RSX_OP_XORF, 1'b1, 5'h1f, 8'h00, 3'h0, 8'ha5, 3'h0, 8'ha5);
      step(RSX_OP_XORL, 1'b0, 5'h00, 8'ha5, 3'h0, 8'h00, 3'h1, 8'h00);
      step(RSX_OP_SWAP, 1'b0, 5'h1f, 8'h00, 3'h0, 8'h5a, 3'h1, 8'ha5);
      $display("logic test done");
   endtask
   task automatic t_rotate();
      step(RSX_OP_ROTL, 1'b1, 5'h1f, 8'h00, 3'h0, 8'h5a, 3'h5, 8'h4a);
      step(RSX_OP_ROTR, 1'b0, 5'h1f, 8'h00, 3'h0, 8'ha5, 3'h1, 8'h4a);
      $display("rotate test done");
   endtask
   task automatic t_subtract();
      step(RSX_OP_SUB, 1'b0, 5'h1f, 8'h00, 3'h0, 8'ha5, 3'h2, 8'h4a);
      step(RSX_OP_SUB, 1'b1, 5'h00, 8'h00, 3'h0, 8'ha5, 3'h0, 8'h5b);
      $display("subtract test done");
   endtask
   task automatic t_direction();
      step(RSX_OP_XORF, 1'b0, 5'h00, 8'h00, 3'h0, 8'hfe, 3'h0, 8'h5b);
      step(RSX_OP_DIR, 1'b0, 5'h00, 8'h00, 3'h6, 8'hfe, 3'h0, 8'h5b);
      `CHK(o_pin_direction, 8'hfe)
      step(RSX_OP_XORL, 1'b0, 5'h00, 8'hfe, 3'h0, 8'h00, 3'h1, 8'h5b);
      // a selector other than 6 must leave the register alone
      step(RSX_OP_DIR, 1'b0, 5'h00, 8'h00, 3'h7, 8'h00, 3'h1, 8'h5b);
      `CHK(o_pin_direction, 8'hfe)
      step(RSX_OP_NONE, 1'b1, 5'h00, 8'h00, 3'h0, 8'h00, 3'h1, 8'h5b);
      $display("direction test done");
   endtask
   // file not below acc: carry and digit carry set, then an equal pair gives zero
   task automatic t_no_borrow();
      step(RSX_OP_SUB, 1'b0, 5'h00, 8'h00, 3'h0, 8'h5b, 3'h6, 8'h5b);
      step(RSX_OP_SUB, 1'b0, 5'h00, 8'h00, 3'h0, 8'h00, 3'h7, 8'h5b);
      $display("no borrow test done");
   endtask
   // old carry of 1 into bit 0, then results steered back to the file
   task automatic t_routing();
      step(RSX_OP_ROTL, 1'b0, 5'h1f, 8'h00, 3'h0, 8'h95, 3'h3, 8'h4a);
      step(RSX_OP_SWAP, 1'b1, 5'h00, 8'h00, 3'h0, 8'h95, 3'h3, 8'hb5);
      step(RSX_OP_ROTR, 1'b1, 5'h00, 8'h00, 3'h0, 8'h95, 3'h7, 8'h5a);
      $display("routing test done");
   endtask
   // two instructions on adjacent edges; the second uses the first's result
   task automatic t_back_to_back();
      @(posedge i_mclk);
      i_valid <= 1'b1;
      i_instr <= '{RSX_OP_XORL, 1'b0, 5'h00, 8'h95, 3'h0};
      i_file_raddr <= 5'h00;
      @(posedge i_mclk);
      i_instr <= '{RSX_OP_XORF, 1'b0, 5'h00, 8'h00, 3'h0};
      #1;
      `CHK(o_acc, 8'h00)
      @(posedge i_mclk);
      i_valid <= 1'b0;
      #1;
      `CHK(o_acc, 8'h5a)
      `CHK(o_flags, 3'h6)
      `CHK(o_file_rdata, 8'h5a)
      $display("back to back test done");
   endtask
   task automatic complete_run();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // reset values are checked while reset is still held
   initial begin
      repeat (4) @(posedge i_mclk);
      `CHK({o_acc, o_flags, o_pin_direction, o_file_rdata}, 27'h000ff00)
      i_reset_n <= 1'b1;
      t_logic();
      t_rotate();
      t_subtract();
      t_direction();
      t_no_borrow();
      t_routing();
      t_back_to_back();
      complete_run();
   end
endmodule
